/* File: bench/ifesc_core_model.sv */
// Core sequencer model: instruction boundaries, sleep, return, stack
`timescale 1ns/100ps
`default_nettype none

module ifesc_core_model
  import ifesc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          cpuHalted,
  input  wire logic          pushByte,
  input  wire logic          popByte,
  input  wire logic          runEn,
  input  wire logic          sleepReq,
  input  wire logic          retReq,
  output var ifesc_core_cmd_t coreCmd,
  output var logic [7:0]     spReg
);
  logic phaseReg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phaseReg <= 1'b0;
      coreCmd  <= '0;
    end else begin
      phaseReg <= ~phaseReg;
      coreCmd.instrDone <= runEn & ~cpuHalted & phaseReg
                           & ~sleepReq & ~retReq;
      coreCmd.sleepInstr <= sleepReq;
      coreCmd.retInstr   <= retReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one step per byte
  always_ff @(posedge core_clk) begin
    if (reset) begin
      spReg <= 8'hFF;
    end else begin
      spReg <= spReg - {7'h00, pushByte} + {7'h00, popByte};
    end
  end
endmodule

`default_nettype wire

/* File: bench/irq_flags_extint_sleep_ctrl_tb.sv */
// Testbench for the interrupt flag, pin and sleep control block
`timescale 1ns/100ps
`default_nettype none

module irq_flags_extint_sleep_ctrl_tb import ifesc_pkg::*;;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ifesc_tmr_evt_t tmrEvt = '0;
  logic [15:0] t1Count = 16'h0;
  logic [15:0] matchAValue = 16'h5;
  logic [15:0] matchBValue = 16'h7;
  logic extPinA = 1'b1;
  logic extPinB = 1'b1;
  ifesc_core_cmd_t coreCmd;
  logic vecTake, pushByte, popByte, cpuHalted, oscStop, gateState;
  logic [3:0] vecNum;
  logic sleepReq = 1'b0;
  logic retReq = 1'b0;
  logic [7:0] spReg;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int vcnt = 0;
  localparam logic [7:0] IDX [8] = '{CTRL_IDX, TFLAG_IDX, TEN_IDX, XFLAG_IDX,
    XMASK_IDX, GATE_IDX, CAPT_IDX, STAT_IDX};
  localparam logic [8:0] EV [8] = '{9'h100, 9'h0C0, 9'h020, 9'h010, 9'h010,
    9'h008, 9'h006, 9'h001};
  localparam logic [15:0] CN [8] = '{16'h0, 16'h0, 16'h1234, 16'h5, 16'h7,
    16'h0, 16'h0, 16'h0};
  localparam logic [7:0] FL [8] = '{8'h40, 8'h40, 8'h20, 8'h10, 8'h08,
    8'h04, 8'h04, 8'h01};

  ifesc_ctrl #(.CNT_W(16), .WAKE_CYCLES(1)) DUT (
    .core_clk(core_clk), .reset(reset), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tmrEvt(tmrEvt), .t1Count(t1Count),
    .matchAValue(matchAValue), .matchBValue(matchBValue),
    .extPinA(extPinA), .extPinB(extPinB), .coreCmd(coreCmd),
    .vecTake(vecTake), .vecNum(vecNum), .pushByte(pushByte),
    .popByte(popByte), .cpuHalted(cpuHalted), .oscStop(oscStop),
    .gateState(gateState));

  ifesc_core_model core (
    .core_clk(core_clk), .reset(reset), .cpuHalted(cpuHalted),
    .pushByte(pushByte), .popByte(popByte), .runEn(1'b1),
    .sleepReq(sleepReq), .retReq(retReq), .coreCmd(coreCmd), .spReg(spReg));

  ////////////////////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (vecTake === 1'b1) vcnt <= vcnt + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    avs_address   <= {idx, 2'b00};
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so the next access never re-drives in this time step
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    acc(1'b1, idx, d, r);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    acc(1'b0, idx, 8'h00, r);
    chk(r, exp);
  endtask

  task automatic waitv(input logic [3:0] v);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (vecTake !== 1'b1 && n < 60);
    chk({31'h0, vecTake}, 32'h1);
    chk({28'h0, vecNum}, {28'h0, v});
  endtask

  task automatic ret();
    retReq <= 1'b1;
    @(posedge core_clk);
    retReq <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic slp();
    sleepReq <= 1'b1;
    @(posedge core_clk);
    sleepReq <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, p, s;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (IDX[k]) rc(IDX[k], 32'h0);
    wr(8'h36, 8'hFF);
    rc(8'h36, 32'h0);
    wr(CTRL_IDX, 8'hFF);
    rc(CTRL_IDX, 32'h7F);
    wr(TEN_IDX, 8'hFF);
    rc(TEN_IDX, 32'h7D);
    wr(CTRL_IDX, 8'h00);
    wr(TEN_IDX, 8'h00);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      t1Count <= CN[i];
      tmrEvt  <= EV[i];
      @(posedge core_clk);
      tmrEvt  <= '0;
      t1Count <= 16'h0;
      @(posedge core_clk);
      rc(TFLAG_IDX, {24'h0, FL[i]});
      wr(TFLAG_IDX, FL[i]);
      rc(TFLAG_IDX, 32'h0);
    end
    rc(CAPT_IDX, 32'h1234);
    $display("test timer flags done");
    wr(TEN_IDX, 8'h01);
    tmrEvt <= 9'h001;
    @(posedge core_clk);
    tmrEvt <= '0;
    repeat (20) @(posedge core_clk);
    chk(vcnt, 0);
    rc(TFLAG_IDX, 32'h1);
    wr(GATE_IDX, 8'h80);
    waitv(VEC_T0_WRAP);
    chk({24'h0, spReg}, 32'hFD);
    chk({31'h0, gateState}, 32'h0);
    rc(TFLAG_IDX, 32'h0);
    ret();
    chk({24'h0, spReg}, 32'hFF);
    chk({31'h0, gateState}, 32'h1);
    $display("test entry and return done");
    wr(XMASK_IDX, 8'hC0);
    wr(CTRL_IDX, 8'h00);
    extPinA <= 1'b0;
    waitv(VEC_EXT_A);
    ret();
    waitv(VEC_EXT_A);
    extPinA <= 1'b1;
    ret();
    wr(GATE_IDX, 8'h00);
    for (p = 0; p < 2; p++) begin
      for (s = 0; s < 4; s++) begin
        wr(CTRL_IDX, 8'(s << (2 * p)));
        if (p == 1) extPinB <= 1'b0;
        else extPinA <= 1'b0;
        repeat (3) @(posedge core_clk);
        extPinA <= 1'b1;
        extPinB <= 1'b1;
        repeat (3) @(posedge core_clk);
        rc(XFLAG_IDX, s[1] ? 32'(8'h40 << p) : 32'h0);
        wr(XFLAG_IDX, 8'hC0);
      end
    end
    $display("test pin sense done");
    wr(GATE_IDX, 8'h80);
    wr(XMASK_IDX, 8'h40);
    wr(CTRL_IDX, 8'h00);
    slp();
    chk({31'h0, cpuHalted}, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(CTRL_IDX, 8'(8'h40 | (i << 4)));
      slp();
      chk({31'h0, cpuHalted}, 32'(i != 1));
      chk({31'h0, oscStop}, 32'(i[1]));
      if (i[1]) begin
        tmrEvt <= 9'h001;
        @(posedge core_clk);
        tmrEvt <= '0;
        repeat (3) @(posedge core_clk);
        chk({31'h0, cpuHalted}, 32'h1);
        wr(TFLAG_IDX, 8'h01);
      end
      extPinA <= 1'b0;
      waitv(VEC_EXT_A);
      chk({31'h0, cpuHalted}, 32'h0);
      extPinA <= 1'b1;
      ret();
    end
    wr(CTRL_IDX, 8'h60);
    slp();
    chk({31'h0, cpuHalted}, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk({30'h0, cpuHalted, oscStop}, 32'h0);
    rc(STAT_IDX, 32'h0);
    $display("test sleep done");
    test_done();
  end
endmodule

`default_nettype wire

/* File: rtl/ifesc_ctrl.sv */
// Interrupt flags, external pin sensing, entry/return and sleep sequencer
//
// Behaviour
// - Timer2 wrap sets flag; vector or write-one clears
// - Pulse-width mode: timer2 leaving zero sets flag
// - Capture copies timer1 value, sets capture flag
// - Timer1 equal to value A sets flag A
// - Timer1 equal to value B sets flag B
// - Timer1 wrap or leaving zero sets flag
// - Timer0 wrap sets flag; vector or write-one clears
// - Take only with gate, enable and flag
// - Flag bit 1, control bit 7 read zero
// - Pins request even when driven as outputs
// - Low-level sense requests while pin stays low
// - Entry: four cycles, two pushes, after instruction
// - Return: four cycles, two pops, gate set
// - One main instruction before next entry
// - Sleep only with sleep permit bit set
// - Kind bits select idle, reserved, down, save
// - Pin B sense: low, reserved, fall, rise
// - Pin A sense: low, reserved, fall, rise
// - Pins sampled; pulses over one clock caught
// - Enabled interrupt wakes from idle; handler, then resume
// - Idle halts core only, wakes without delay
// - Power-down stops oscillator; level pin wakes
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ifesc_ctrl
  import ifesc_pkg::*;
#(
  parameter int unsigned CNT_W       = 16,
  parameter int unsigned WAKE_CYCLES = 4
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire ifesc_tmr_evt_t    tmrEvt,
  input  wire logic [CNT_W-1:0]  t1Count,
  input  wire logic [CNT_W-1:0]  matchAValue,
  input  wire logic [CNT_W-1:0]  matchBValue,
  input  wire logic              extPinA,
  input  wire logic              extPinB,
  input  wire ifesc_core_cmd_t   coreCmd,
  output logic                   vecTake,
  output logic      [3:0]        vecNum,
  output logic                   pushByte,
  output logic                   popByte,
  output logic                   cpuHalted,
  output logic                   oscStop,
  output logic                   gateState
);

  localparam int unsigned WAKE_W = $clog2(WAKE_CYCLES + 1);

  generate
    if (CNT_W < 1 || CNT_W > 32 || WAKE_CYCLES < 1) begin : gBadParam
      $error("ifesc_ctrl: unsupported parameter values");
    end
  endgenerate

  ifesc_seq_t          state_reg;
  logic [1:0]          cnt_reg;
  logic [WAKE_W-1:0]   wakeCnt_reg;
  logic [3:0]          entryVec_reg;
  logic                waitReq_reg;
  logic [31:0]         readData_reg;
  logic [7:0]          ctrl_reg;
  logic [7:0]          tf_reg;
  logic [7:0]          ten_reg;
  logic [7:0]          xmask_reg;
  logic                gate_reg;
  logic [1:0]          xflag_reg;
  logic [1:0]          pinSamp_reg;
  logic [1:0]          pinPrev_reg;
  logic [CNT_W-1:0]    capt_reg;
  logic                vecTake_reg;
  logic [3:0]          vecNum_reg;
  logic                pushByte_reg;
  logic                popByte_reg;
  logic                cpuHalted_reg;
  logic                oscStop_reg;

  logic                busReq;
  logic                wrAcc;
  logic [7:0]          regSel;
  logic                aligned;
  logic [7:0]          wb;
  logic [31:0]         rdMux;
  logic [1:0]          xEdge;
  logic [1:0]          xLevel;
  logic [1:0]          xMaskBits;
  logic [1:0]          sense [2];
  logic [7:0]          tfSet;
  logic [7:0]          hwClrTf;
  logic [1:0]          hwClrX;
  logic [8:0]          pend;
  logic                anyTake;
  logic                clrHw;
  logic [1:0]          napKind;
  logic                deepWake;

  assign avs_readdata    = readData_reg;
  assign avs_waitrequest = waitReq_reg;
  assign vecTake         = vecTake_reg;
  assign vecNum          = vecNum_reg;
  assign pushByte        = pushByte_reg;
  assign popByte         = popByte_reg;
  assign cpuHalted       = cpuHalted_reg;
  assign oscStop         = oscStop_reg;
  assign gateState       = gate_reg;

  function automatic logic [3:0] firstVec(input logic [8:0] p);
    logic [3:0] v;
    v = 4'h0;
    for (int k = 8; k >= 0; k--) begin
      if (p[k]) begin
        v = 4'(k + 1);
      end
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register bus slave

  assign busReq  = avs_read | avs_write;
  assign wrAcc   = avs_write & ~waitReq_reg;
  assign regSel  = avs_address[ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign wb      = avs_writedata[7:0];

  always_comb begin
    rdMux = 32'h0000_0000;
    if (aligned) begin
      case (regSel)
        CTRL_IDX:  rdMux = {24'h00_0000, ctrl_reg};
        TFLAG_IDX: rdMux = {24'h00_0000, tf_reg};
        TEN_IDX:   rdMux = {24'h00_0000, ten_reg};
        XFLAG_IDX: rdMux = {24'h00_0000, xflag_reg, 6'h00};
        XMASK_IDX: rdMux = {24'h00_0000, xmask_reg};
        GATE_IDX:  rdMux = {24'h00_0000, gate_reg, 7'h00};
        CAPT_IDX:  rdMux = 32'(capt_reg);
        STAT_IDX:  rdMux = {24'h00_0000, entryVec_reg,
                            state_reg == ST_RETURN,
                            state_reg == ST_ENTRY,
                            oscStop_reg, cpuHalted_reg};
        default:   rdMux = 32'h0000_0000;
      endcase
    end
  end

  // One wait cycle per access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitReq_reg  <= 1'b1;
      readData_reg <= 32'h0000_0000;
    end else if (ce) begin
      waitReq_reg <= ~(busReq & waitReq_reg);
      if (avs_read && waitReq_reg) begin
        readData_reg <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg  <= REG_RESET;
      ten_reg   <= REG_RESET;
      xmask_reg <= REG_RESET;
    end else if (ce && wrAcc && aligned) begin
      if (regSel == CTRL_IDX) begin
        ctrl_reg <= wb & CTRL_WMASK;
      end
      if (regSel == TEN_IDX) begin
        ten_reg <= wb & TF_WMASK;
      end
      if (regSel == XMASK_IDX) begin
        xmask_reg <= wb & 8'hC0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // External pins

  assign sense[0]  = ctrl_reg[CTRL_SENSEA +: 2];
  assign sense[1]  = ctrl_reg[CTRL_SENSEB +: 2];
  assign xMaskBits = {xmask_reg[XB_BIT], xmask_reg[XA_BIT]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinSamp_reg <= 2'h3;
      pinPrev_reg <= 2'h3;
    end else if (ce) begin
      pinSamp_reg <= {extPinB, extPinA};
      pinPrev_reg <= pinSamp_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (sense[i])
        SENSE_FALL: xEdge[i] = pinPrev_reg[i] & ~pinSamp_reg[i];
        SENSE_RISE: xEdge[i] = ~pinPrev_reg[i] & pinSamp_reg[i];
        default:    xEdge[i] = 1'b0;
      endcase
      xLevel[i] = (sense[i] == SENSE_LOW) & ~pinSamp_reg[i];
    end
  end

  // Edge flags: set wins over clear, held clear in level mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      xflag_reg <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (xEdge[i]) begin
          xflag_reg[i] <= 1'b1;
        end else if (sense[i] == SENSE_LOW || hwClrX[i] ||
                     (wrAcc && aligned && regSel == XFLAG_IDX &&
                      wb[XA_BIT + i])) begin
          xflag_reg[i] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer flags

  always_comb begin
    tfSet = 8'h00;
    tfSet[TF_T2]   = tmrEvt.t2Pwm ? tmrEvt.t2Bottom : tmrEvt.t2Wrap;
    tfSet[TF_CAPT] = tmrEvt.capture;
    tfSet[TF_MA]   = tmrEvt.t1Tick && (t1Count == matchAValue);
    tfSet[TF_MB]   = tmrEvt.t1Tick && (t1Count == matchBValue);
    tfSet[TF_T1]   = tmrEvt.t1Pwm ? tmrEvt.t1Bottom : tmrEvt.t1Wrap;
    tfSet[TF_T0]   = tmrEvt.t0Wrap;
  end

  always_comb begin
    hwClrTf = 8'h00;
    hwClrX  = 2'h0;
    if (clrHw) begin
      case (entryVec_reg)
        VEC_EXT_A:   hwClrX[0]        = 1'b1;
        VEC_EXT_B:   hwClrX[1]        = 1'b1;
        VEC_T2_WRAP: hwClrTf[TF_T2]   = 1'b1;
        VEC_CAPT:    hwClrTf[TF_CAPT] = 1'b1;
        VEC_MATCH_A: hwClrTf[TF_MA]   = 1'b1;
        VEC_MATCH_B: hwClrTf[TF_MB]   = 1'b1;
        VEC_T1_WRAP: hwClrTf[TF_T1]   = 1'b1;
        VEC_T0_WRAP: hwClrTf[TF_T0]   = 1'b1;
        default:     hwClrTf          = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tf_reg <= REG_RESET;
    end else if (ce) begin
      tf_reg <= ((tf_reg & ~(hwClrTf |
                 ((wrAcc && aligned && regSel == TFLAG_IDX) ? wb : 8'h00)))
                 | tfSet) & TF_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      capt_reg <= '0;
    end else if (ce && tmrEvt.capture) begin
      capt_reg <= t1Count;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request qualification and sequencer

  assign pend = {tf_reg[TF_T0] & ten_reg[TF_T0],
                 tf_reg[TF_T1] & ten_reg[TF_T1],
                 tf_reg[TF_MB] & ten_reg[TF_MB],
                 tf_reg[TF_MA] & ten_reg[TF_MA],
                 tf_reg[TF_CAPT] & ten_reg[TF_CAPT],
                 tf_reg[TF_T2] & ten_reg[TF_T2],
                 1'b0,
                 (xflag_reg[1] | xLevel[1]) & xMaskBits[1],
                 (xflag_reg[0] | xLevel[0]) & xMaskBits[0]};
  assign anyTake  = gate_reg & (|pend);
  assign clrHw    = (state_reg == ST_ENTRY) &&
                    (cnt_reg == 2'(ENTRY_CYCLES - 2));
  assign napKind  = ctrl_reg[CTRL_KIND_LO +: 2];
  assign deepWake = gate_reg & (|(xLevel & xMaskBits));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg     <= ST_RUN;
      cnt_reg       <= 2'h0;
      wakeCnt_reg   <= '0;
      entryVec_reg  <= 4'h0;
      gate_reg      <= 1'b0;
      vecTake_reg   <= 1'b0;
      vecNum_reg    <= 4'h0;
      pushByte_reg  <= 1'b0;
      popByte_reg   <= 1'b0;
      cpuHalted_reg <= 1'b0;
      oscStop_reg   <= 1'b0;
    end else if (ce) begin
      vecTake_reg  <= 1'b0;
      pushByte_reg <= 1'b0;
      popByte_reg  <= 1'b0;
      if (wrAcc && aligned && regSel == GATE_IDX) begin
        gate_reg <= wb[GATE_BIT];
      end
      unique case (state_reg)
        ST_RUN: begin
          if (coreCmd.retInstr) begin
            state_reg <= ST_RETURN;
            cnt_reg   <= 2'h0;
          end else if (coreCmd.sleepInstr && ctrl_reg[CTRL_PERMIT] &&
                       napKind != NAP_RSVD) begin
            state_reg     <= ST_SLEEP;
            cpuHalted_reg <= 1'b1;
            oscStop_reg   <= napKind[1];
          end else if (coreCmd.instrDone && anyTake) begin
            state_reg    <= ST_ENTRY;
            cnt_reg      <= 2'h0;
            entryVec_reg <= firstVec(pend);
            gate_reg     <= 1'b0;
          end
        end
        ST_ENTRY: begin
          cnt_reg      <= cnt_reg + 2'h1;
          pushByte_reg <= (cnt_reg < 2'h2);
          if (clrHw) begin
            vecTake_reg <= 1'b1;
            vecNum_reg  <= entryVec_reg;
          end
          if (cnt_reg == 2'(ENTRY_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RETURN: begin
          cnt_reg     <= cnt_reg + 2'h1;
          popByte_reg <= (cnt_reg < 2'h2);
          if (cnt_reg == 2'(RETURN_CYCLES - 2)) begin
            gate_reg <= 1'b1;
          end
          if (cnt_reg == 2'(RETURN_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          if (napKind == NAP_IDLE && anyTake) begin
            state_reg     <= ST_ENTRY;
            cnt_reg       <= 2'h0;
            entryVec_reg  <= firstVec(pend);
            gate_reg      <= 1'b0;
            cpuHalted_reg <= 1'b0;
          end else if (napKind[1] && deepWake) begin
            state_reg   <= ST_WAKE;
            wakeCnt_reg <= '0;
            oscStop_reg <= 1'b0;
          end
        end
        ST_WAKE: begin
          wakeCnt_reg <= wakeCnt_reg + WAKE_W'(1);
          if (wakeCnt_reg == WAKE_W'(WAKE_CYCLES - 1)) begin
            cpuHalted_reg <= 1'b0;
            if (anyTake) begin
              state_reg    <= ST_ENTRY;
              cnt_reg      <= 2'h0;
              entryVec_reg <= firstVec(pend);
              gate_reg     <= 1'b0;
            end else begin
              state_reg <= ST_RUN;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || !ce);

  chk_entry_push_seq: assert property (
    $rose(state_reg == ST_ENTRY) |->
      ##1 pushByte ##1 pushByte ##1 (vecTake && !pushByte))
    else $error("entry push or vector timing wrong");

  chk_return_pop_gate: assert property (
    $rose(state_reg == ST_RETURN) |->
      ##1 popByte ##1 popByte ##1 (gateState && !popByte))
    else $error("return pop or gate timing wrong");

  chk_take_gate_en: assert property (
    ($rose(state_reg == ST_ENTRY) && $past(state_reg == ST_RUN)) |->
      $past(gate_reg && (|pend)))
    else $error("entry without gate, enable and flag");

  chk_one_instr: assert property (
    ($fell(state_reg == ST_RETURN) && !coreCmd.instrDone) |=>
      state_reg != ST_ENTRY)
    else $error("entry right after return");

  chk_flag_rsvd_zero: assert property (
    (avs_read && waitReq_reg && aligned &&
     (regSel == TFLAG_IDX || regSel == CTRL_IDX)) |=>
      (avs_readdata[1] == 1'b0 || $past(regSel) == CTRL_IDX) &&
      (avs_readdata[7] == 1'b0 || $past(regSel) == TFLAG_IDX))
    else $error("reserved bit reads one");

  chk_level_req: assert property (
    (sense[0] == SENSE_LOW && xMaskBits[0] && !pinSamp_reg[0]) |->
      pend[0])
    else $error("low pin not requesting");

  chk_fall_flag: assert property (
    (sense[0] == SENSE_FALL && $fell(extPinA)) |=> ##1 xflag_reg[0])
    else $error("falling edge on pin A missed");

  chk_t0_set_wins: assert property (
    tmrEvt.t0Wrap |=> tf_reg[TF_T0])
    else $error("timer0 wrap flag lost");

  chk_t2_pwm_set: assert property (
    (tmrEvt.t2Pwm && tmrEvt.t2Bottom) |=> tf_reg[TF_T2])
    else $error("timer2 leaving zero flag lost");

  chk_capture_copy: assert property (
    tmrEvt.capture |=> (capt_reg == $past(t1Count)) && tf_reg[TF_CAPT])
    else $error("capture copy or flag wrong");

  chk_sleep_permit: assert property (
    $rose(cpuHalted) |-> $past(ctrl_reg[CTRL_PERMIT]))
    else $error("sleep without permit");

  chk_idle_fast_wake: assert property (
    (state_reg == ST_SLEEP && napKind == NAP_IDLE && anyTake) |=>
      !cpuHalted && !oscStop)
    else $error("idle wake delayed");

  cov_entry:   cover property ($rose(vecTake));
  cov_return:  cover property ($fell(state_reg == ST_RETURN));
  cov_idle:    cover property ($fell(cpuHalted) && !$past(oscStop));
  cov_deep:    cover property ($fell(oscStop));

endmodule

`default_nettype wire

/* File: rtl/ifesc_pkg.sv */
// Constants and carrier types for the interrupt flag, pin and sleep control
package ifesc_pkg;

  localparam int unsigned ADDR_W = 10;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] CTRL_IDX  = 8'h35;
  localparam logic [7:0] TFLAG_IDX = 8'h38;
  localparam logic [7:0] TEN_IDX   = 8'h39;
  localparam logic [7:0] XFLAG_IDX = 8'h3A;
  localparam logic [7:0] XMASK_IDX = 8'h3B;
  localparam logic [7:0] GATE_IDX  = 8'h3F;
  localparam logic [7:0] CAPT_IDX  = 8'h41;
  localparam logic [7:0] STAT_IDX  = 8'h42;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Control register fields
  localparam int unsigned CTRL_PERMIT  = 6;
  localparam int unsigned CTRL_KIND_LO = 4;
  localparam int unsigned CTRL_SENSEB  = 2;
  localparam int unsigned CTRL_SENSEA  = 0;
  localparam logic [7:0]  CTRL_WMASK   = 8'h7F;

  // Timer flag and enable fields
  localparam int unsigned TF_T2    = 6;
  localparam int unsigned TF_CAPT  = 5;
  localparam int unsigned TF_MA    = 4;
  localparam int unsigned TF_MB    = 3;
  localparam int unsigned TF_T1    = 2;
  localparam int unsigned TF_T0    = 0;
  localparam logic [7:0]  TF_WMASK = 8'h7D;

  // Pin flag and mask fields, gate bit
  localparam int unsigned XB_BIT   = 7;
  localparam int unsigned XA_BIT   = 6;
  localparam int unsigned GATE_BIT = 7;

  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  localparam logic [1:0] NAP_IDLE  = 2'h0;
  localparam logic [1:0] NAP_RSVD  = 2'h1;

  localparam logic [3:0] VEC_EXT_A   = 4'h1;
  localparam logic [3:0] VEC_EXT_B   = 4'h2;
  localparam logic [3:0] VEC_T2_WRAP = 4'h4;
  localparam logic [3:0] VEC_CAPT    = 4'h5;
  localparam logic [3:0] VEC_MATCH_A = 4'h6;
  localparam logic [3:0] VEC_MATCH_B = 4'h7;
  localparam logic [3:0] VEC_T1_WRAP = 4'h8;
  localparam logic [3:0] VEC_T0_WRAP = 4'h9;

  localparam int unsigned ENTRY_CYCLES  = 4;
  localparam int unsigned RETURN_CYCLES = 4;

  typedef enum logic [2:0] {
    ST_RUN, ST_ENTRY, ST_RETURN, ST_SLEEP, ST_WAKE
  } ifesc_seq_t;

  typedef struct packed {
    logic t2Wrap;
    logic t2Bottom;
    logic t2Pwm;
    logic capture;
    logic t1Tick;
    logic t1Wrap;
    logic t1Bottom;
    logic t1Pwm;
    logic t0Wrap;
  } ifesc_tmr_evt_t;

  typedef struct packed {
    logic instrDone;
    logic sleepInstr;
    logic retInstr;
  } ifesc_core_cmd_t;

endpackage
